// ---- src/fsk_pkg.sv ----
// package for the flash security backdoor unlock block
// assumes a byte-wide cpu/debug access port on one bus clock
package fsk_pkg;
  localparam int KEY_BYTES = 8;
  localparam logic [15:0] KEY_BASE_ADDR = 16'hFFB0;
  localparam logic [15:0] OPT_ADDR = 16'hFFBF;
  localparam logic [15:0] PROT_ADDR = 16'hFFBD;
  localparam logic [15:0] CFG_ADDR = 16'hFFBE;
  localparam logic [15:0] NV_BLOCK_BASE = 16'hFE00;
  localparam logic [15:0] NV_BLOCK_MASK = 16'hFE00;
  localparam int KEY_ACC_BIT = 5;
  localparam int KEY_EN_BIT = 7;
  localparam int SEC_LSB = 0;
  localparam logic [1:0] SEC_UNSECURE = 2'h2;
  localparam logic [1:0] SEC_SECURE = 2'h3;
  localparam logic [7:0] PROT_RESET = 8'hFF;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] OPT_RESET = 8'hFF;
  localparam int HP_REGS = 9;
  localparam int HP_LOADED = 3;
  typedef enum logic [2:0] {
    FSK_LOAD = 3'h1,
    FSK_RUN = 3'h2,
    FSK_KEY = 3'h4
  } fsk_state_e;
endpackage : fsk_pkg

// ---- src/fsk_key_cmp.sv ----
// key comparator: collects eight ordered key bytes and compares them
// assumes byte writes arrive as one-cycle strobes from the main module
`timescale 1ns/1ps
module fsk_key_cmp (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control
  input wire logic clear,
  input wire logic wr_stb,
  input wire logic [2:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [63:0] stored_key,
  // result
  output logic match
);
  logic [63:0] got_ff, nxt_got;
  logic [3:0] cnt_ff, nxt_cnt;
  logic ok_ff, nxt_ok;

  // a byte out of order spoils the whole entry
  always_comb begin
    nxt_got = got_ff;
    nxt_cnt = cnt_ff;
    nxt_ok = ok_ff;
    if (clear) begin
      nxt_got = 64'h0;
      nxt_cnt = 4'h0;
      nxt_ok = 1'b1;
    end else if (wr_stb) begin
      if (cnt_ff[3] || wr_idx != cnt_ff[2:0]) nxt_ok = 1'b0;
      nxt_got[wr_idx*8 +: 8] = wr_data;
      if (!cnt_ff[3]) nxt_cnt = cnt_ff + 4'h1;
    end
  end

  // registers only
  always_ff @(posedge core_clk) begin
    if (rst) begin
      got_ff <= 64'h0;
      cnt_ff <= 4'h0;
      ok_ff <= 1'b1;
    end else begin
      got_ff <= nxt_got;
      cnt_ff <= nxt_cnt;
      ok_ff <= nxt_ok;
    end
  end

  assign match = ok_ff && cnt_ff[3] && (got_ff == stored_key);
endmodule : fsk_key_cmp

// ---- src/fsk_unlock.sv ----
// flash security control with backdoor key unlock and debug blank-check unlock
// assumes the flash array, its program engine and blank check live outside;
// bus strobes are one-cycle pulses on core_clk
// the unlock lives only in flops, so every reset secures the block again
// unless the option byte itself says unsecured; a key entry is judged on
// the config write that ends it, so a program that never clears key mode
// leaves the array unreadable until reset
//
// Summary of operation
// - backdoor unlock only when key enable set
// - key mode turns key writes into comparisons
// - key mode cleared with match unsecures
// - key entry accepted only from RAM code
// - flash reads blocked while key mode set
// - key stored in nonvolatile flash space
// - key shares protected vector block
// - user programs cannot change block protection
// - protection writes only from debug commands
// - blank check pass unsecures until reset
// - reset loads three nonvolatile bytes to registers
`timescale 1ns/1ps
module fsk_unlock (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // bus access
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic from_ram,
  input wire logic from_debug,
  // flash array view
  input wire logic [63:0] nv_key,
  input wire logic [7:0] nv_opt,
  input wire logic [7:0] nv_prot,
  input wire logic [7:0] nv_cfg,
  input wire logic blank_done,
  input wire logic blank_ok,
  // outputs
  output logic [1:0] security_state_field,
  output logic secured,
  output logic key_access_mode,
  output logic [7:0] block_protect_reg,
  output logic [7:0] flash_config_reg,
  output logic [7:0] option_reg,
  output logic flash_rd_block,
  output logic flash_wr_pass,
  output logic vector_block_protected
);
  // security state machine and its shadow registers
  fsk_pkg::fsk_state_e st_ff, nxt_st;
  logic [1:0] sec_ff, nxt_sec;
  logic [7:0] cfg_ff, nxt_cfg;
  logic [7:0] opt_ff, nxt_opt;
  // protection shadow, rewritten only from debug
  logic [7:0] prot_ff, nxt_prot;
  // registered strobes and flags toward the flash array
  logic rdblk_ff, nxt_rdblk;
  logic pass_ff, nxt_pass;
  logic vprot_ff, nxt_vprot;
  logic secured_ff, nxt_secured;
  // decoded bus accesses
  logic key_hit;
  logic cfg_wr;
  logic prot_wr;
  logic in_nvblk;
  // comparator handshake
  logic key_clear;
  logic key_stb;
  logic key_match;

  // address decode; the key window is the eight bytes from the base upward
  assign key_hit = addr[15:3] == fsk_pkg::KEY_BASE_ADDR[15:3];
  assign cfg_wr = wr_stb && addr == fsk_pkg::CFG_ADDR;
  assign prot_wr = wr_stb && addr == fsk_pkg::PROT_ADDR && from_debug;
  assign in_nvblk = (addr & fsk_pkg::NV_BLOCK_MASK) == fsk_pkg::NV_BLOCK_BASE;
  // only ram code may feed the comparator; debug pokes are dropped
  assign key_stb = wr_stb && key_hit && cfg_ff[fsk_pkg::KEY_ACC_BIT] && from_ram
    && !from_debug;
  // a fresh entry starts on any config write that sets key mode while it is 0
  assign key_clear = cfg_wr && wdata[fsk_pkg::KEY_ACC_BIT]
    && !cfg_ff[fsk_pkg::KEY_ACC_BIT];

  // byte collector and comparator against the flash-resident key
  fsk_key_cmp u_cmp (
    .core_clk(core_clk),
    .rst(rst),
    .clear(key_clear),
    .wr_stb(key_stb),
    .wr_idx(addr[2:0]),
    .wr_data(wdata),
    .stored_key(nv_key),
    .match(key_match)
  );

  // option shadow: copied once after reset and read-only afterwards, so the
  // key enable bit cannot be switched on by the program that wants to use it
  always_comb begin
    nxt_opt = opt_ff;
    if (st_ff == fsk_pkg::FSK_LOAD) nxt_opt = nv_opt;
  end

  // option register only
  always_ff @(posedge core_clk) begin
    if (rst) begin
      opt_ff <= fsk_pkg::OPT_RESET;
    end else begin
      opt_ff <= nxt_opt;
    end
  end

  // protection shadow: loaded once after reset, then only debug may rewrite
  // it, so a user program holding the key can never loosen the vector block
  always_comb begin
    nxt_prot = prot_ff;
    if (st_ff == fsk_pkg::FSK_LOAD) nxt_prot = nv_prot;
    if (prot_wr) nxt_prot = wdata;
  end

  // protection register only
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prot_ff <= fsk_pkg::PROT_RESET;
    end else begin
      prot_ff <= nxt_prot;
    end
  end

  // security state machine: load nonvolatile copies, then run
  always_comb begin
    nxt_st = st_ff;
    nxt_sec = sec_ff;
    nxt_cfg = cfg_ff;
    unique case (st_ff)
      // one cycle to copy the nonvolatile bytes; key mode never survives it
      fsk_pkg::FSK_LOAD: begin
        nxt_cfg = nv_cfg & ~(8'h01 << fsk_pkg::KEY_ACC_BIT);
        nxt_sec = nv_opt[fsk_pkg::SEC_LSB +: 2];
        nxt_st = fsk_pkg::FSK_RUN;
      end
      // normal running: only a config write can open key mode
      fsk_pkg::FSK_RUN: begin
        if (cfg_wr) begin
          nxt_cfg = wdata;
          // key mode only reachable with backdoor_key_enable
          if (!opt_ff[fsk_pkg::KEY_EN_BIT]) nxt_cfg[fsk_pkg::KEY_ACC_BIT] = 1'b0;
          if (nxt_cfg[fsk_pkg::KEY_ACC_BIT]) nxt_st = fsk_pkg::FSK_KEY;
        end
      end
      // key mode: the config write that clears the bit judges the entry
      fsk_pkg::FSK_KEY: begin
        if (cfg_wr) begin
          nxt_cfg = wdata;
          nxt_cfg[fsk_pkg::KEY_ACC_BIT] = wdata[fsk_pkg::KEY_ACC_BIT];
          if (!wdata[fsk_pkg::KEY_ACC_BIT]) begin
            nxt_st = fsk_pkg::FSK_RUN;
            if (key_match && opt_ff[fsk_pkg::KEY_EN_BIT]) nxt_sec = fsk_pkg::SEC_UNSECURE;
          end
        end
      end
      default: nxt_st = fsk_pkg::FSK_LOAD;
    endcase
    // a blank check pass wins over anything the key path does
    if (blank_done && blank_ok) nxt_sec = fsk_pkg::SEC_UNSECURE;
  end

  // derived strobes toward the flash array
  always_comb begin
    // read block follows the next config value so it rises with key mode
    nxt_rdblk = nxt_cfg[fsk_pkg::KEY_ACC_BIT];
    // key bytes in key mode and writes into a protected vector block stop here
    nxt_pass = wr_stb && !(key_hit && cfg_ff[fsk_pkg::KEY_ACC_BIT])
      && !(in_nvblk && !prot_ff[0]);
    nxt_vprot = !nxt_prot[0];
    // secured gets its own flop so the output is not a compare of sec_ff
    nxt_secured = nxt_sec != fsk_pkg::SEC_UNSECURE;
  end

  // state registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff <= fsk_pkg::FSK_LOAD;
      sec_ff <= fsk_pkg::SEC_SECURE;
      cfg_ff <= fsk_pkg::CFG_RESET;
    end else begin
      st_ff <= nxt_st;
      sec_ff <= nxt_sec;
      cfg_ff <= nxt_cfg;
    end
  end

  // strobe registers; the block comes out of reset secured
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdblk_ff <= 1'b0;
      pass_ff <= 1'b0;
      vprot_ff <= 1'b0;
      secured_ff <= 1'b1;
    end else begin
      rdblk_ff <= nxt_rdblk;
      pass_ff <= nxt_pass;
      vprot_ff <= nxt_vprot;
      secured_ff <= nxt_secured;
    end
  end

  // outputs straight from their registers
  assign security_state_field = sec_ff;
  assign secured = secured_ff;
  assign key_access_mode = cfg_ff[fsk_pkg::KEY_ACC_BIT];
  assign block_protect_reg = prot_ff;
  assign flash_config_reg = cfg_ff;
  assign option_reg = opt_ff;
  assign flash_rd_block = rdblk_ff;
  assign flash_wr_pass = pass_ff;
  assign vector_block_protected = vprot_ff;
endmodule : fsk_unlock

// ---- test/fsk_unlock_checker.sv ----
// checker for the fsk_unlock ports: key, protect and blank check paths
// assumes one core_clk domain and synchronous active-high rst
`timescale 1ns/1ps
module fsk_unlock_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // bus access watched
  input wire logic wr_stb,
  input wire logic from_debug,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  // blank check result
  input wire logic blank_done,
  input wire logic blank_ok,
  // block outputs
  input wire logic [1:0] security_state_field,
  input wire logic secured,
  input wire logic key_access_mode,
  input wire logic [7:0] block_protect_reg,
  input wire logic [7:0] flash_config_reg,
  input wire logic [7:0] option_reg,
  input wire logic flash_rd_block,
  input wire logic flash_wr_pass,
  input wire logic vector_block_protected
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // decoded accesses
  wire logic cfg_w = wr_stb && addr == fsk_pkg::CFG_ADDR;
  wire logic prot_w = wr_stb && addr == fsk_pkg::PROT_ADDR;
  wire logic key_w = wr_stb && (addr & 16'hFFF8) == fsk_pkg::KEY_BASE_ADDR;
  wire logic nv_w = wr_stb && (addr & fsk_pkg::NV_BLOCK_MASK) == fsk_pkg::NV_BLOCK_BASE;
  wire logic unsec = security_state_field == fsk_pkg::SEC_UNSECURE;
  // port relations
  chk_key_en_off: assert property (cfg_w && !option_reg[7] |=> !key_access_mode)
    else $error("key mode entered with key enable off");
  chk_key_no_pass: assert property (key_w && key_access_mode |=> !flash_wr_pass)
    else $error("key byte forwarded to flash");
  chk_rd_blocked: assert property (flash_rd_block == key_access_mode)
    else $error("read block differs from key mode");
  chk_unsec_holds: assert property (unsec |=> unsec)
    else $error("unsecured state lost before reset");
  chk_unsec_cause: assert property ($rose(unsec) |-> $past(rst) || $past(rst, 2) ||
    $past(blank_done && blank_ok) || $past(cfg_w && key_access_mode))
    else $error("unsecured without cause");
  chk_prot_user: assert property (prot_w && !from_debug |=> $stable(block_protect_reg))
    else $error("user write changed protection");
  chk_prot_debug: assert property (prot_w && from_debug |=>
    block_protect_reg == $past(wdata))
    else $error("debug protect write lost");
  chk_vec_flag: assert property (vector_block_protected == !block_protect_reg[0])
    else $error("vector protect flag wrong");
  chk_vec_no_pass: assert property (nv_w && vector_block_protected |=> !flash_wr_pass)
    else $error("write passed into protected block");
  chk_blank_unsec: assert property (blank_done && blank_ok |=> unsec)
    else $error("blank pass did not unsecure");
  chk_secured_out: assert property (secured == !unsec)
    else $error("secured flag wrong");
  // main scenarios reached
  cover property ($rose(unsec) && $past(cfg_w));
  cover property (prot_w && from_debug);
  cover property (blank_done && blank_ok);
endmodule : fsk_unlock_checker

bind fsk_unlock fsk_unlock_checker chk (.*);

// ---- test/fsk_host.sv ----
// bus-master partner: cpu and debug host byte writes on core_clk
// assumes the bench calls wr and key one at a time
`timescale 1ns/1ps
module fsk_host (
  // clock
  input wire logic core_clk,
  // bus side
  output logic wr_stb,
  output logic rd_stb,
  output logic [15:0] addr,
  output logic [7:0] wdata,
  output logic from_ram,
  output logic from_debug
);
  // idle bus at time zero; reads never issued
  initial begin
    wr_stb = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    from_ram = 1'b0;
    from_debug = 1'b0;
  end
  assign rd_stb = 1'b0;
  // one strobe then an idle edge, so key bytes never sit back to back
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic ram, input logic dbg);
    @(posedge core_clk) #1;
    wr_stb = 1'b1;
    addr = a;
    wdata = d;
    from_ram = ram;
    from_debug = dbg;
    @(posedge core_clk) #1;
    wr_stb = 1'b0;
    addr = ~addr; // released bus shows no stale value
    wdata = ~wdata;
  endtask : wr
  // key bytes strictly from base upward
  task automatic key(input logic [63:0] k, input logic ram, input logic dbg);
    for (int i = 0; i < fsk_pkg::KEY_BYTES; i++) begin
      wr(fsk_pkg::KEY_BASE_ADDR + 16'(i), k[8*i+:8], ram, dbg);
    end
  endtask : key
endmodule : fsk_host

// ---- test/fsk_unlock_tb.sv ----
// testbench for fsk_unlock: backdoor key, debug protect and blank check
// assumes fsk_host drives the bus; flash copies are driven here
`timescale 1ns/1ps
module fsk_unlock_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wr_stb, rd_stb, from_ram, from_debug, secured, key_access_mode;
  logic flash_rd_block, flash_wr_pass, vector_block_protected;
  logic blank_done = 1'b0;
  logic blank_ok = 1'b0;
  logic [15:0] addr;
  logic [7:0] wdata, block_protect_reg, flash_config_reg, option_reg;
  logic [7:0] nv_opt = 8'hFF;
  logic [7:0] nv_prot = 8'hFE;
  logic [7:0] nv_cfg = 8'hA0;
  logic [63:0] nv_key = 64'hF0E1D2C3B4A59687;
  logic [1:0] security_state_field;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #12.5 core_clk = ~core_clk;
  fsk_host host (.*);
  fsk_unlock dut (.*);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic do_rst(input logic [7:0] opt);
    rst = 1'b1;
    nv_opt = opt;
    repeat (10) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk(option_reg, opt);
    chk(flash_config_reg, 8'h80);
    chk({6'h00, security_state_field}, {6'h00, opt[1:0]});
  endtask : do_rst
  task automatic t_key(input logic [7:0] opt, input logic [63:0] k, input logic dbg,
                       input logic [1:0] exp);
    do_rst(opt);
    host.wr(fsk_pkg::CFG_ADDR, 8'h20, 1'b1, 1'b0);
    chk({7'h00, flash_rd_block}, {7'h00, opt[7]});
    chk({7'h00, key_access_mode}, {7'h00, opt[7]});
    host.key(k, 1'b1, dbg);
    host.wr(fsk_pkg::CFG_ADDR, 8'h00, 1'b1, 1'b0);
    chk({6'h00, security_state_field}, {6'h00, exp});
    chk({7'h00, key_access_mode}, 8'h00);
    chk({7'h00, secured}, {7'h00, exp != fsk_pkg::SEC_UNSECURE});
  endtask : t_key
  // option byte programmed unsecured: the block comes out of reset open
  task automatic t_opt;
    do_rst(8'hFE);
    chk({7'h00, secured}, 8'h00);
  endtask : t_opt
  task automatic t_prot;
    do_rst(8'hFF);
    host.wr(fsk_pkg::PROT_ADDR, 8'hFF, 1'b1, 1'b0);
    chk(block_protect_reg, 8'hFE);
    chk({7'h00, vector_block_protected}, 8'h01);
    host.wr(16'hFE10, 8'h55, 1'b1, 1'b0);
    chk({7'h00, flash_wr_pass}, 8'h00);
    host.wr(fsk_pkg::PROT_ADDR, 8'hFF, 1'b0, 1'b1);
    chk(block_protect_reg, 8'hFF);
    chk({7'h00, vector_block_protected}, 8'h00);
    host.wr(16'hFE10, 8'h55, 1'b1, 1'b0);
    chk({7'h00, flash_wr_pass}, 8'h01);
    blank_done = 1'b1;
    blank_ok = 1'b1;
    @(posedge core_clk) #1;
    blank_done = 1'b0;
    chk({6'h00, security_state_field}, 8'h02);
    chk({7'h00, secured}, 8'h00);
  endtask : t_prot
  task automatic close_out;
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // hang guard, far above the roughly 160 cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end
  // scenarios in sequence
  initial begin
    t_key(8'hFF, nv_key, 1'b0, 2'h2);
    t_key(8'hFF, nv_key ^ 64'h1, 1'b0, 2'h3);
    t_key(8'h7F, nv_key, 1'b0, 2'h3);
    t_key(8'hFF, nv_key, 1'b1, 2'h3);
    t_prot();
    t_opt();
    close_out();
  end
endmodule : fsk_unlock_tb
